// ### verilog/dpram_port_host.sv
/*
 * host-side controller for one port of an asynchronous dual-port ram.
 * takes array or flag reads and writes on a simple request port and
 * drives the ram pins with strobe-controlled cycles.
 * assumes the ram is wired to these pins directly; data pins are
 * two-way and resolved outside by the enable.
 */
`timescale 1ns/10ps
module dpram_port_host (
    input wire logic clk_sys_i, // system clock
    input wire logic rstn_i, // async reset, active low
    input wire logic req_valid_i, // request present
    output logic req_ready_o, // request taken this cycle
    input wire logic req_write_i, // 1 write, 0 read
    input wire logic req_flag_i, // 1 flag space, 0 array
    input wire logic [dpram_host_pkg::ADDR_W-1:0] req_addr_i, // address
    input wire logic [dpram_host_pkg::DATA_W-1:0] req_wdata_i, // write data
    input wire logic [1:0] req_bytes_i, // byte lanes, bit1 high byte
    output logic rsp_valid_o, // read data valid pulse
    output logic [dpram_host_pkg::DATA_W-1:0] rsp_rdata_o, // read data
    input wire logic busy_n_i, // ram busy, active low
    output logic [dpram_host_pkg::ADDR_W-1:0] addr_o, // ram address
    output logic chip_enable_n_o, // ram chip enable
    output logic flag_space_select_n_o, // ram flag space select
    output logic write_n_o, // ram write strobe
    output logic output_enable_n_o, // ram output enable
    output logic high_byte_enable_n_o, // ram high byte lane
    output logic low_byte_enable_n_o, // ram low byte lane
    output logic [dpram_host_pkg::DATA_W-1:0] data_o, // data to ram
    output logic data_oe_o, // host drives data pins
    input wire logic [dpram_host_pkg::DATA_W-1:0] data_i // data from ram
);
    import dpram_host_pkg::*;

    host_state_type state_reg, state_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [1:0] bytes_reg, bytes_next;
    logic write_reg, write_next;
    logic flag_reg, flag_next;
    logic ce_n_reg, ce_n_next;
    logic sem_n_reg, sem_n_next;
    logic we_n_reg, we_n_next;
    logic oe_n_reg, oe_n_next;
    logic ub_n_reg, ub_n_next;
    logic lb_n_reg, lb_n_next;
    logic doe_reg, doe_next;
    logic rsp_reg, rsp_next;
    logic flag_wr_reg, flag_wr_next;
    logic load;
    logic [3:0] load_count;
    logic wait_done;
    logic [DATA_W-1:0] rd_sync1_reg, rd_sync2_reg;
    logic busy_sync1_reg, busy_sync2_reg;

    // pin inputs pass two flops before use
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_sync1_reg <= '0;
            rd_sync2_reg <= '0;
            busy_sync1_reg <= 1'b1;
            busy_sync2_reg <= 1'b1;
        end else begin
            rd_sync1_reg <= data_i;
            rd_sync2_reg <= rd_sync1_reg;
            busy_sync1_reg <= busy_n_i;
            busy_sync2_reg <= busy_sync1_reg;
        end
    end

    dpram_wait_counter u_wait (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .load_i(load),
        .count_i(load_count),
        .done_o(wait_done)
    );

    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        bytes_next = bytes_reg;
        write_next = write_reg;
        flag_next = flag_reg;
        ce_n_next = ce_n_reg;
        sem_n_next = sem_n_reg;
        we_n_next = we_n_reg;
        oe_n_next = oe_n_reg;
        ub_n_next = ub_n_reg;
        lb_n_next = lb_n_reg;
        doe_next = doe_reg;
        rsp_next = 1'b0;
        flag_wr_next = flag_wr_reg;
        load = 1'b0;
        load_count = 4'h0;
        req_ready_o = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                // address only moves here, all strobes high
                if (req_valid_i && wait_done) begin
                    req_ready_o = 1'b1;
                    addr_next = req_addr_i;
                    wdata_next = req_wdata_i;
                    bytes_next = req_bytes_i;
                    write_next = req_write_i;
                    flag_next = req_flag_i;
                    ce_n_next = req_flag_i;
                    sem_n_next = !req_flag_i;
                    if (req_flag_i) begin
                        ub_n_next = 1'b0;
                        lb_n_next = 1'b0;
                    end else begin
                        ub_n_next = !req_bytes_i[1];
                        lb_n_next = !req_bytes_i[0];
                    end
                    load = 1'b1;
                    load_count = SETUP_CYC;
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // enables settled; strobe now falls last and times the write
                if (wait_done) begin
                    load = 1'b1;
                    if (write_reg) begin
                        we_n_next = 1'b0;
                        doe_next = oe_n_reg;
                        load_count = oe_n_reg ? WP_CYC : WP_OE_CYC;
                        state_next = ST_PULSE;
                    end else begin
                        oe_n_next = 1'b0;
                        load_count = RD_CYC + SYNC_CYC;
                        state_next = ST_READ;
                    end
                end
            end
            ST_PULSE: begin
                if (wait_done) begin
                    we_n_next = 1'b1;
                    flag_wr_next = flag_reg;
                    state_next = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                // release data and enables after strobe rises
                doe_next = 1'b0;
                ce_n_next = 1'b1;
                sem_n_next = 1'b1;
                ub_n_next = 1'b1;
                lb_n_next = 1'b1;
                state_next = ST_IDLE;
                if (flag_wr_reg) begin
                    load = 1'b1;
                    load_count = SWRD_CYC;
                    flag_wr_next = 1'b0;
                    state_next = ST_FLAG_GAP;
                end
            end
            ST_FLAG_GAP: begin
                if (wait_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_READ: begin
                // wait out access time, then busy for same-address contention on array reads
                if (wait_done && (busy_sync2_reg || flag_reg)) begin
                    rdata_next = rd_sync2_reg;
                    rsp_next = 1'b1;
                    oe_n_next = 1'b1;
                    ce_n_next = 1'b1;
                    sem_n_next = 1'b1;
                    ub_n_next = 1'b1;
                    lb_n_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_IDLE;
            addr_reg <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            bytes_reg <= 2'h0;
            write_reg <= 1'b0;
            flag_reg <= 1'b0;
            ce_n_reg <= 1'b1;
            sem_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            ub_n_reg <= 1'b1;
            lb_n_reg <= 1'b1;
            doe_reg <= 1'b0;
            rsp_reg <= 1'b0;
            flag_wr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            bytes_reg <= bytes_next;
            write_reg <= write_next;
            flag_reg <= flag_next;
            ce_n_reg <= ce_n_next;
            sem_n_reg <= sem_n_next;
            we_n_reg <= we_n_next;
            oe_n_reg <= oe_n_next;
            ub_n_reg <= ub_n_next;
            lb_n_reg <= lb_n_next;
            doe_reg <= doe_next;
            rsp_reg <= rsp_next;
            flag_wr_reg <= flag_wr_next;
        end
    end

    assign addr_o = addr_reg;
    assign chip_enable_n_o = ce_n_reg;
    assign flag_space_select_n_o = sem_n_reg;
    assign write_n_o = we_n_reg;
    assign output_enable_n_o = oe_n_reg;
    assign high_byte_enable_n_o = ub_n_reg;
    assign low_byte_enable_n_o = lb_n_reg;
    assign data_o = wdata_reg;
    assign data_oe_o = doe_reg;
    assign rsp_valid_o = rsp_reg;
    assign rsp_rdata_o = rdata_reg;
endmodule // dpram_port_host

// ### verilog/dpram_host_pkg.sv
/*
 * constants for the host-side port controller of an asynchronous
 * dual-port static ram: widths, timing figures and derived cycle counts.
 * assumes a 50 MHz system clock.
 */
package dpram_host_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 18;
    localparam int CLK_PERIOD_NS = 20;
    // timing figures in ns, slowest grade
    localparam int T_WC_NS = 15;
    localparam int T_EW_NS = 12;
    localparam int T_WP_NS = 12;
    localparam int T_DW_NS = 10;
    localparam int T_WZ_NS = 4;
    localparam int T_RC_NS = 15;
    localparam int T_AA_NS = 15;
    localparam int T_SAA_NS = 20;
    localparam int T_SWRD_NS = 5;
    // derived cycle counts, least times rounded up, at least one
    localparam int WP_MIN_NS = (T_WP_NS > T_WZ_NS + T_DW_NS) ? T_WP_NS : T_WZ_NS + T_DW_NS;
    localparam int WP_OE_CYC_I = (WP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC_I = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_CYC_I = (T_SAA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SWRD_CYC_I = (T_SWRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] WP_OE_CYC = 4'(WP_OE_CYC_I < 1 ? 1 : WP_OE_CYC_I);
    localparam logic [3:0] WP_CYC = 4'(WP_CYC_I < 1 ? 1 : WP_CYC_I);
    localparam logic [3:0] RD_CYC = 4'(RD_CYC_I < 1 ? 1 : RD_CYC_I);
    localparam logic [3:0] SWRD_CYC = 4'(SWRD_CYC_I < 1 ? 1 : SWRD_CYC_I);
    localparam logic [3:0] SETUP_CYC = 4'h1;
    // read data passes two synchroniser stages before it is taken
    localparam logic [3:0] SYNC_CYC = 4'h2;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_PULSE, ST_RECOVER, ST_READ, ST_FLAG_GAP
    } host_state_type;
endpackage

// ### verilog/dpram_wait_counter.sv
/*
 * down-counter that times the phases of one port access.
 * assumes the loader holds load_i for one cycle with the wanted count.
 */
`timescale 1ns/10ps
module dpram_wait_counter (
    input wire logic clk_sys_i, // system clock
    input wire logic rstn_i, // async reset, active low
    input wire logic load_i, // one-cycle load pulse
    input wire logic [3:0] count_i, // cycles to wait
    output logic done_o // high when count is zero
);
    logic [3:0] count_reg;
    logic [3:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (load_i) begin
            count_next = count_i;
        end else if (count_reg != 4'h0) begin
            count_next = count_reg - 4'h1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_reg <= 4'h0;
        end else begin
            count_reg <= count_next;
        end
    end

    // pure register decode; load_i feeds back from done_o in the loader
    assign done_o = (count_reg == 4'h0);
endmodule // dpram_wait_counter

// ### verif/dpram_model.sv
/* behavioural model of one ram port as seen by the host controller.
   assumes its pins are wired straight to the controller; busy follows hold_i. */
`timescale 1ns/10ps
module dpram_model (
    input wire logic [dpram_host_pkg::ADDR_W-1:0] addr_i, // address
    input wire logic ce_n_i, // chip enable
    input wire logic sem_n_i, // flag space select
    input wire logic we_n_i, // write strobe
    input wire logic oe_n_i, // output enable
    input wire logic ub_n_i, // high byte lane
    input wire logic lb_n_i, // low byte lane
    input wire logic [dpram_host_pkg::DATA_W-1:0] host_d_i, // host data
    input wire logic host_oe_i, // host drives pins
    input wire logic hold_i, // keep busy asserted
    output logic busy_n_o, // busy pin
    output logic [dpram_host_pkg::DATA_W-1:0] pins_o // resolved data pins
);
    import dpram_host_pkg::*;
    logic [DATA_W-1:0] mem [64];
    logic [7:0] flag;
    logic [DATA_W-1:0] val;
    logic drive;
    initial begin
        foreach (mem[i]) mem[i] = '0;
        flag = 8'hff;
    end
    // store at the end of the overlap, whichever enable rises first
    always @(posedge we_n_i or posedge ce_n_i or posedge sem_n_i) begin
        if (we_n_i != ce_n_i && sem_n_i) begin
            if (!ub_n_i) mem[addr_i[5:0]][17:9] <= pins_o[17:9];
            if (!lb_n_i) mem[addr_i[5:0]][8:0] <= pins_o[8:0];
        end
        if (we_n_i != sem_n_i && ce_n_i) flag[addr_i[2:0]] <= pins_o[0];
    end
    assign drive = we_n_i && !oe_n_i && (!sem_n_i || (!ce_n_i && !(ub_n_i && lb_n_i)));
    assign val = !sem_n_i ? {DATA_W{flag[addr_i[2:0]]}} : mem[addr_i[5:0]];
    // released pins show the inverse, never the last value
    assign pins_o = host_oe_i ? host_d_i : (drive ? val : ~val);
    assign busy_n_o = !hold_i;
endmodule // dpram_model

// ### verif/dpram_port_host_chk.sv
/* concurrent checks on the ram pins of the port host controller.
   assumes binding into dpram_port_host; one clock domain. */
`timescale 1ns/10ps
module dpram_port_host_chk (
    input wire logic clk_sys_i, // system clock
    input wire logic rstn_i, // async reset, active low
    input wire logic req_ready_o, // request taken
    input wire logic rsp_valid_o, // read answer
    input wire logic [dpram_host_pkg::ADDR_W-1:0] addr_o, // ram address
    input wire logic chip_enable_n_o, // chip enable
    input wire logic flag_space_select_n_o, // flag select
    input wire logic write_n_o, // write strobe
    input wire logic output_enable_n_o, // output enable
    input wire logic [dpram_host_pkg::DATA_W-1:0] data_o, // write data
    input wire logic data_oe_o // host drives pins
);
    import dpram_host_pkg::*;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    property p_sel; chip_enable_n_o || flag_space_select_n_o; endproperty
    a_sel: assert property (p_sel) else $error("array and flag selected together");
    property p_flag; !flag_space_select_n_o |=> chip_enable_n_o; endproperty
    a_flag: assert property (p_flag) else $error("chip enable low around flag access");
    property p_stable;
        !write_n_o |-> $stable(chip_enable_n_o) && $stable(flag_space_select_n_o);
    endproperty
    a_stable: assert property (p_stable) else $error("select moved in write");
    property p_addr; $changed(addr_o) |-> write_n_o; endproperty
    a_addr: assert property (p_addr) else $error("address moved in write");
    property p_noconf; data_oe_o |-> output_enable_n_o; endproperty
    a_noconf: assert property (p_noconf) else $error("both sides drive data");
    property p_pulse;
        $fell(write_n_o) |-> output_enable_n_o throughout (##[1:4] $rose(write_n_o));
    endproperty
    a_pulse: assert property (p_pulse) else $error("bad write pulse");
    property p_wdata; !write_n_o |-> data_oe_o && $stable(data_o); endproperty
    a_wdata: assert property (p_wdata) else $error("write data not held");
    property p_gap;
        $rose(write_n_o) && !flag_space_select_n_o |=> output_enable_n_o [*4];
    endproperty
    a_gap: assert property (p_gap) else $error("flag read too soon");
    property p_idle; req_ready_o |-> write_n_o && output_enable_n_o; endproperty
    a_idle: assert property (p_idle) else $error("take while busy");
    c_write: cover property ($rose(write_n_o) && !chip_enable_n_o);
    c_flag: cover property ($rose(write_n_o) && !flag_space_select_n_o);
    c_read: cover property (rsp_valid_o);
endmodule // dpram_port_host_chk
bind dpram_port_host dpram_port_host_chk i_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .addr_o(addr_o),
    .chip_enable_n_o(chip_enable_n_o), .flag_space_select_n_o(flag_space_select_n_o),
    .write_n_o(write_n_o), .output_enable_n_o(output_enable_n_o), .data_o(data_o),
    .data_oe_o(data_oe_o));

// ### verif/tb_dpram_port_host.sv
/* self-checking bench for the ram port host controller.
   assumes the behavioural ram model and the bound checker. */
`timescale 1ns/10ps
`define CHECK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin \
    error_cnt++; $display("wrong value at %0t: %s", $time, msg); end end
module tb_dpram_port_host;
    import dpram_host_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic req_valid, req_write, req_flag, req_ready, rsp_valid, busy_n, data_oe, hold;
    logic ce_n, sem_n, we_n, oe_n, ub_n, lb_n;
    logic [1:0] req_bytes, b;
    logic [ADDR_W-1:0] req_addr, addr, a;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, data_out, pins, d, q;
    logic [DATA_W-1:0] ref_mem [64];
    logic [7:0] ref_flag;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    dpram_port_host i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_valid_i(req_valid),
        .req_ready_o(req_ready), .req_write_i(req_write), .req_flag_i(req_flag),
        .req_addr_i(req_addr), .req_wdata_i(req_wdata), .req_bytes_i(req_bytes),
        .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata), .busy_n_i(busy_n), .addr_o(addr),
        .chip_enable_n_o(ce_n), .flag_space_select_n_o(sem_n), .write_n_o(we_n),
        .output_enable_n_o(oe_n), .high_byte_enable_n_o(ub_n), .low_byte_enable_n_o(lb_n),
        .data_o(data_out), .data_oe_o(data_oe), .data_i(pins));
    dpram_model i_ram (.addr_i(addr), .ce_n_i(ce_n), .sem_n_i(sem_n), .we_n_i(we_n),
        .oe_n_i(oe_n), .ub_n_i(ub_n), .lb_n_i(lb_n), .host_d_i(data_out),
        .host_oe_i(data_oe), .hold_i(hold), .busy_n_o(busy_n), .pins_o(pins));
    function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] old, nv, logic [1:0] lanes);
        return {lanes[1] ? nv[17:9] : old[17:9], lanes[0] ? nv[8:0] : old[8:0]};
    endfunction
    task give_verdict;
        if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task access(input logic w, f, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd,
                input logic [1:0] lanes);
        int n;
        req_write = w;
        req_flag = f;
        req_addr = ad;
        req_wdata = wd;
        req_bytes = lanes;
        req_valid = 1'b1;
        n = 0;
        #1;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk_sys_i);
            n++;
        end
        @(negedge clk_sys_i);
        req_valid = 1'b0;
        `CHECK(n < 50, 1'b1, "request not taken")
        @(negedge clk_sys_i);
    endtask
    task read_wait(output logic [DATA_W-1:0] rd);
        int n;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 60) begin
            @(negedge clk_sys_i);
            n++;
        end
        rd = rsp_rdata;
        `CHECK(n < 60, 1'b1, "no read answer")
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict;
        end
    end
    initial begin
        {req_valid, req_write, req_flag, hold} = 4'h0;
        req_addr = '0;
        req_wdata = '0;
        req_bytes = 2'h0;
        foreach (ref_mem[i]) ref_mem[i] = '0;
        ref_flag = 8'hff;
        repeat (5) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        void'($urandom(71));
        // random array traffic, every lane mix and the top address first
        for (int i = 0; i < 24; i++) begin
            a = (i == 0) ? 18'h3ffff : 18'($urandom);
            d = 18'($urandom);
            b = (i < 4) ? 2'(i) : 2'($urandom);
            access(1'b1, 1'b0, a, d, b);
            ref_mem[a[5:0]] = merge(ref_mem[a[5:0]], d, b);
            access(1'b0, 1'b0, a, '0, 2'h3);
            read_wait(q);
            `CHECK(q, ref_mem[a[5:0]], "array read")
        end
        // flag written then read straight back on lines 0 to 3
        for (int i = 0; i < 4; i++) begin
            access(1'b1, 1'b1, 18'(i), 18'(i & 1), 2'h0);
            ref_flag[i] = i[0];
            access(1'b0, 1'b1, 18'(i), '0, 2'h0);
            read_wait(q);
            `CHECK(q, {DATA_W{ref_flag[i]}}, "flag read")
        end
        // array read held off while busy
        hold = 1'b1;
        access(1'b0, 1'b0, 18'h5, '0, 2'h3);
        repeat (10) begin
            @(negedge clk_sys_i);
            `CHECK(rsp_valid, 1'b0, "answer during busy")
        end
        hold = 1'b0;
        read_wait(q);
        `CHECK(q, ref_mem[5], "read after busy")
        give_verdict;
    end
endmodule // tb_dpram_port_host
